/* File: verilog/amc_pkg.sv */
// Purpose: Shared constants for the depth and antenna calibration sequencer.
// Assumes: Core clock at 100 MHz; registers reached over a plain strobe port.
// Notes:   Offsets are register indexes on a 6-bit address space.
package amc_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TRIM_W = 4;

  localparam logic [ADDR_W-1:0] ADDR_ADC_OUT     = 6'h0D;
  localparam logic [ADDR_W-1:0] ADDR_ANT_CAL     = 6'h0E;
  localparam logic [ADDR_W-1:0] ADDR_DEPTH_DEF   = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_DEPTH_DISP  = 6'h11;
  localparam logic [ADDR_W-1:0] ADDR_AM_LEVEL    = 6'h12;
  localparam logic [ADDR_W-1:0] ADDR_NONMOD_LVL  = 6'h13;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND     = 6'h20;

  localparam logic [7:0] CMD_CAL_DEPTH   = 8'h01;
  localparam logic [7:0] CMD_CAL_ANTENNA = 8'h02;
  localparam logic [7:0] CMD_CHECK_RES   = 8'h03;
  localparam logic [7:0] CMD_MEASURE_RF  = 8'h04;

  localparam int unsigned LEVEL_SRC_BIT  = 7;
  localparam int unsigned FRAC_HI_BIT    = 6;
  localparam int unsigned FRAC_LO_BIT    = 1;
  localparam int unsigned FRAC_W         = 6;
  localparam int unsigned ANT_ERR_BIT    = 4;

  localparam logic [DATA_W-1:0] RST_DEPTH_DEF  = 8'h00;
  localparam logic [DATA_W-1:0] RST_AM_LEVEL   = 8'h00;
  localparam logic [DATA_W-1:0] RST_NONMOD_LVL = 8'h00;
  localparam logic [DATA_W-1:0] LEVEL_MAX      = 8'hFF;
  localparam logic [TRIM_W-1:0] TRIM_ALL_ON    = 4'hF;
  localparam logic [TRIM_W-1:0] TRIM_ALL_OFF   = 4'h0;

  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned TRIM_SETTLE_US  = 10;
  localparam int unsigned TX_SETTLE_US    = 10;
  localparam int unsigned TRIM_SETTLE_CYC = (TRIM_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TX_SETTLE_CYC   = (TX_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAIT_W          = 11;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DC_TXON,
    ST_DC_MEAS0,
    ST_DC_STEP,
    ST_DC_MEAS,
    ST_AC_SETTLE,
    ST_AC_STEP,
    ST_ADC_ONLY
  } amc_state_type;

endpackage

/* File: verilog/amc_cal_seq.sv */
// Purpose: Sequencer for modulation depth calibration, antenna tuning and resonance checks.
// Assumes: Converter and phase detector sit outside; converter handshake is on core_clk.
// Notes:   The phase comparator is asynchronous and is synchronised before use.
//
// The address-and-strobe port and the register addresses are this design's own decisions.

// How it works
// - Driver strength is an 8-bit binary-weighted code; higher code means weaker carrier.
// - Depth calibration enables transmitter at non-modulated level, measures and stores carrier.
// - Target equals stored carrier divided by one plus six-bit fraction.
// - Internal level starts at non-modulated code, steps by one, remeasures and compares.
// - Stepping repeats while the measured carrier stays above target and the level is below 255.
// - At or below target, level goes to result register and drives modulated state.
// - Level source select high takes modulated level from the host-written register.
// - Resonance check routes phase detector to converter in relative mode.
// - Mid-range result means tuned; above means resonance high, below means low.
// - Both pads of each binary weight come from one shared control bit.
// - Antenna calibration watches the phase comparator, high means resonance above target.
// - Start with all switches off; comparator low there sets error and ends.
// - While comparator high, advance switches, wait 10 us, sample again until low or full.
// - All switches on with comparator still high sets the error flag.
// - A readable register holds the four switch bits and the error flag.
// - Fraction sits in bits 6 to 1; bit 7 zero selects calibrated level.
module amc_cal_seq
(
  input  wire logic                         core_clk,
  input  wire logic                         resetn,
  input  wire logic [amc_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [amc_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_write,
  input  wire logic                         reg_read,
  output logic      [amc_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                         tx_enable_request,
  input  wire logic                         am_modulate,
  output logic                              tx_enable,
  output logic      [amc_pkg::DATA_W-1:0]   antenna_driver_out_a,
  output logic      [amc_pkg::DATA_W-1:0]   antenna_driver_out_b,
  output logic      [amc_pkg::TRIM_W-1:0]   tuning_switch_a,
  output logic      [amc_pkg::TRIM_W-1:0]   tuning_switch_b,
  output logic                              adc_start,
  output logic                              adc_relative,
  output logic                              adc_phase_select,
  input  wire logic                         adc_done,
  input  wire logic [amc_pkg::DATA_W-1:0]   adc_data,
  input  wire logic                         phase_comp_async,
  output logic                              busy
);
  import amc_pkg::*;

  initial
    if (TRIM_SETTLE_CYC >= (1 << WAIT_W) || TX_SETTLE_CYC >= (1 << WAIT_W))
      $error("Settle count does not fit the wait counter.");
  localparam logic [WAIT_W-1:0] TRIM_WAIT = WAIT_W'(TRIM_SETTLE_CYC - 1);
  localparam logic [WAIT_W-1:0] TX_WAIT   = WAIT_W'(TX_SETTLE_CYC - 1);
  logic                comp_meta;
  logic                comp_sync;

  // Only the second stage is ever read.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end
    else
    begin
      comp_meta <= phase_comp_async;
      comp_sync <= comp_meta;
    end
  end

  amc_state_type       state;
  amc_state_type       next_state;
  logic [DATA_W-1:0]   depth_def;
  logic [DATA_W-1:0]   next_depth_def;
  logic [DATA_W-1:0]   am_level;
  logic [DATA_W-1:0]   next_am_level;
  logic [DATA_W-1:0]   nonmod_level;
  logic [DATA_W-1:0]   next_nonmod_level;
  logic [DATA_W-1:0]   depth_result;
  logic [DATA_W-1:0]   next_depth_result;
  logic [DATA_W-1:0]   adc_result;
  logic [DATA_W-1:0]   next_adc_result;
  logic [DATA_W-1:0]   carrier_meas;
  logic [DATA_W-1:0]   next_carrier_meas;
  logic [DATA_W-1:0]   target_level;
  logic [DATA_W-1:0]   next_target_level;
  logic [DATA_W-1:0]   cal_level;
  logic [DATA_W-1:0]   next_cal_level;
  logic [TRIM_W-1:0]   trim_code;
  logic [TRIM_W-1:0]   next_trim_code;
  logic                ant_error;
  logic                next_ant_error;
  logic [WAIT_W-1:0]   wait_cnt;
  logic [WAIT_W-1:0]   next_wait_cnt;
  logic                next_adc_start;
  logic                next_relative;
  logic                next_phase_sel;
  logic [DATA_W-1:0]   next_rdata;
  logic [DATA_W-1:0]   next_drive;
  logic                next_tx_enable;
  logic                next_busy;
  logic [DATA_W-1:0]   drive;
  logic [DATA_W-1:0]   mod_level;
  logic [2*DATA_W-3:0] quotient;
  logic                cmd_write;

  assign cmd_write = reg_write && (reg_addr == ADDR_COMMAND) && (state == ST_IDLE);
  // Dividing a scaled-up carrier keeps six fractional bits without a fixed-point divider.
  assign quotient = {carrier_meas, 6'h00} / {8'h01, depth_def[FRAC_HI_BIT:FRAC_LO_BIT]};
  always_comb
  begin
    next_state        = state;
    next_depth_def    = depth_def;
    next_am_level     = am_level;
    next_nonmod_level = nonmod_level;
    next_depth_result = depth_result;
    next_adc_result   = adc_result;
    next_carrier_meas = carrier_meas;
    next_target_level = target_level;
    next_cal_level    = cal_level;
    next_trim_code    = trim_code;
    next_ant_error    = ant_error;
    next_wait_cnt     = (wait_cnt != '0) ? wait_cnt - 1'b1 : wait_cnt;
    next_adc_start    = 1'b0;
    next_relative     = adc_relative;
    next_phase_sel    = adc_phase_select;
    if (reg_write)
    begin
      case (reg_addr)
        ADDR_DEPTH_DEF:  next_depth_def    = {reg_wdata[DATA_W-1:1], 1'b0};
        ADDR_AM_LEVEL:   next_am_level     = reg_wdata;
        ADDR_NONMOD_LVL: next_nonmod_level = reg_wdata;
        default:         next_depth_def    = depth_def;
      endcase
    end
    case (state)
      ST_IDLE:
      begin
        if (cmd_write)
        begin
          case (reg_wdata)
            CMD_CAL_DEPTH:
            begin
              next_cal_level = nonmod_level;
              next_wait_cnt  = TX_WAIT;
              next_state     = ST_DC_TXON;
            end
            CMD_CAL_ANTENNA:
            begin
              next_trim_code = TRIM_ALL_OFF;
              next_ant_error = 1'b0;
              next_wait_cnt  = TRIM_WAIT;
              next_state     = ST_AC_SETTLE;
            end
            CMD_CHECK_RES:
            begin
              next_relative  = 1'b1;
              next_phase_sel = 1'b1;
              next_adc_start = 1'b1;
              next_state     = ST_ADC_ONLY;
            end
            CMD_MEASURE_RF:
            begin
              next_relative  = 1'b0;
              next_phase_sel = 1'b0;
              next_adc_start = 1'b1;
              next_state     = ST_ADC_ONLY;
            end
            default: next_state = ST_IDLE;
          endcase
        end
      end
      ST_ADC_ONLY:
      begin
        if (adc_done)
        begin
          next_adc_result = adc_data;
          next_state      = ST_IDLE;
        end
      end
      ST_DC_TXON:
      begin
        if (wait_cnt == '0)
        begin
          next_relative  = 1'b0;
          next_phase_sel = 1'b0;
          next_adc_start = 1'b1;
          next_state     = ST_DC_MEAS0;
        end
      end
      ST_DC_MEAS0:
      begin
        if (adc_done)
        begin
          next_carrier_meas = adc_data;
          next_adc_result   = adc_data;
          next_state        = ST_DC_STEP;
          next_wait_cnt     = TX_WAIT;
          next_cal_level    = (cal_level == LEVEL_MAX) ? cal_level : cal_level + 1'b1;
        end
      end
      ST_DC_STEP:
      begin
        next_target_level = quotient[DATA_W-1:0];
        if (wait_cnt == '0)
        begin
          next_adc_start = 1'b1;
          next_state     = ST_DC_MEAS;
        end
      end
      ST_DC_MEAS:
      begin
        if (adc_done)
        begin
          next_adc_result = adc_data;
          if (adc_data <= target_level || cal_level == LEVEL_MAX)
          begin
            next_depth_result = cal_level;
            next_state        = ST_IDLE;
          end
          else
          begin
            next_cal_level = cal_level + 1'b1;
            next_wait_cnt  = TX_WAIT;
            next_state     = ST_DC_STEP;
          end
        end
      end
      ST_AC_SETTLE:
      begin
        if (wait_cnt == '0)
          next_state = ST_AC_STEP;
      end
      ST_AC_STEP:
      begin
        if (!comp_sync)
        begin
          next_ant_error = (trim_code == TRIM_ALL_OFF);
          next_state     = ST_IDLE;
        end
        else if (trim_code == TRIM_ALL_ON)
        begin
          next_ant_error = 1'b1;
          next_state     = ST_IDLE;
        end
        else
        begin
          next_trim_code = trim_code + 1'b1;
          next_wait_cnt  = TRIM_WAIT;
          next_state     = ST_AC_SETTLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  assign mod_level = depth_def[LEVEL_SRC_BIT] ? am_level : depth_result;
  assign drive     = (state == ST_DC_STEP || state == ST_DC_MEAS || state == ST_DC_MEAS0 ||
                      state == ST_DC_TXON) ? cal_level : (am_modulate ? mod_level : nonmod_level);

  always_comb
  begin
    next_drive     = drive;
    next_busy      = (next_state != ST_IDLE);
    next_tx_enable = tx_enable_request || next_busy;
    next_rdata     = '0;
    if (reg_read)
    begin
      case (reg_addr)
        ADDR_ADC_OUT:    next_rdata = adc_result;
        ADDR_ANT_CAL:    next_rdata = {3'h0, ant_error, trim_code};
        ADDR_DEPTH_DEF:  next_rdata = depth_def;
        ADDR_DEPTH_DISP: next_rdata = depth_result;
        ADDR_AM_LEVEL:   next_rdata = am_level;
        ADDR_NONMOD_LVL: next_rdata = nonmod_level;
        ADDR_COMMAND:    next_rdata = {7'h00, busy};
        default:         next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state                <= ST_IDLE;
      depth_def            <= RST_DEPTH_DEF;
      am_level             <= RST_AM_LEVEL;
      nonmod_level         <= RST_NONMOD_LVL;
      depth_result         <= '0;
      adc_result           <= '0;
      carrier_meas         <= '0;
      target_level         <= '0;
      cal_level            <= '0;
      trim_code            <= TRIM_ALL_OFF;
      ant_error            <= 1'b0;
      wait_cnt             <= '0;
      adc_start            <= 1'b0;
      adc_relative         <= 1'b0;
      adc_phase_select     <= 1'b0;
      reg_rdata            <= '0;
      antenna_driver_out_a <= RST_NONMOD_LVL;
      antenna_driver_out_b <= RST_NONMOD_LVL;
      tuning_switch_a      <= TRIM_ALL_OFF;
      tuning_switch_b      <= TRIM_ALL_OFF;
      tx_enable            <= 1'b0;
      busy                 <= 1'b0;
    end
    else
    begin
      state                <= next_state;
      depth_def            <= next_depth_def;
      am_level             <= next_am_level;
      nonmod_level         <= next_nonmod_level;
      depth_result         <= next_depth_result;
      adc_result           <= next_adc_result;
      carrier_meas         <= next_carrier_meas;
      target_level         <= next_target_level;
      cal_level            <= next_cal_level;
      trim_code            <= next_trim_code;
      ant_error            <= next_ant_error;
      wait_cnt             <= next_wait_cnt;
      adc_start            <= next_adc_start;
      adc_relative         <= next_relative;
      adc_phase_select     <= next_phase_sel;
      reg_rdata            <= next_rdata;
      antenna_driver_out_a <= next_drive;
      antenna_driver_out_b <= next_drive;
      tuning_switch_a      <= next_trim_code;
      tuning_switch_b      <= next_trim_code;
      tx_enable            <= next_tx_enable;
      busy                 <= next_busy;
    end
  end

endmodule

/* File: verif/amc_cal_seq_assertions.sv */
// Purpose: Port-level timing checks for the calibration sequencer.
// Assumes: The host keeps am_modulate low while a command runs.
// Notes:   Trim settle spacing is measured by a saturating counter.
module amc_cal_seq_assertions
  import amc_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       am_modulate,
  input wire logic       busy,
  input wire logic       tx_enable,
  input wire logic [7:0] antenna_driver_out_a,
  input wire logic [7:0] antenna_driver_out_b,
  input wire logic [3:0] tuning_switch_a,
  input wire logic [3:0] tuning_switch_b,
  input wire logic       adc_start,
  input wire logic       adc_relative,
  input wire logic       adc_phase_select
);
  logic [15:0] since_trim;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  always_ff @(posedge core_clk)
  begin
    if (!resetn || $changed(tuning_switch_a))
      since_trim <= 16'h0000;
    else if (since_trim != 16'hFFFF)
      since_trim <= since_trim + 16'h0001;
  end

  AST_DRV_PAIR: assert property (antenna_driver_out_a == antenna_driver_out_b)
    else $error("driver codes differ");
  AST_TRIM_PAIR: assert property (tuning_switch_a == tuning_switch_b)
    else $error("trim codes differ");
  AST_TX_BUSY: assert property (busy |-> tx_enable)
    else $error("transmitter off during a command");
  AST_ADC_PULSE: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  AST_CHECK_MODE: assert property (adc_start && adc_phase_select |-> adc_relative)
    else $error("phase conversion not in relative mode");
  AST_LVL_STEP: assert property (busy && $past(busy) && !am_modulate && $changed(antenna_driver_out_a)
    |-> (antenna_driver_out_a == $past(antenna_driver_out_a) + 8'h01) or (##1 !busy))
    else $error("driver level did not step by one");
  AST_TRIM_STEP: assert property (busy && $past(busy) && $changed(tuning_switch_a) && tuning_switch_a != 4'h0
    |-> tuning_switch_a == $past(tuning_switch_a) + 4'h1)
    else $error("trim code did not step by one");
  AST_TRIM_WAIT: assert property (busy && $changed(tuning_switch_a) && tuning_switch_a != 4'h0
    |-> since_trim >= 16'(TRIM_SETTLE_CYC - 1))
    else $error("trim stepped before the settle time");
endmodule

bind amc_cal_seq amc_cal_seq_assertions i_amc_cal_seq_assertions (.*);

/* File: verif/amc_far_side.sv */
// Purpose: Converter and phase comparator model beside the sequencer.
// Assumes: Carrier amplitude falls by one step per driver code step.
// Notes:   Data lines toggle between results so stale values never match.
module amc_far_side
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] antenna_driver_out_a,
  input  wire logic [3:0] tuning_switch_a,
  input  wire logic       adc_start,
  input  wire logic       adc_phase_select,
  input  wire logic       slow,
  input  wire logic [4:0] res_point,
  input  wire logic [7:0] phase_level,
  output logic            adc_done,
  output logic      [7:0] adc_data,
  output logic            phase_comp_async
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  logic       pending;

  // Resonance stays above target until enough capacitance is switched in.
  assign phase_comp_async = ({1'b0, tuning_switch_a} < res_point);

  always_ff @(posedge core_clk)
  begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (!resetn)
    begin
      pending <= 1'b0;
      wait_cnt <= 4'h0;
      adc_data <= 8'h5A;
    end
    else if (adc_start)
    begin
      pending <= 1'b1;
      wait_cnt <= slow ? 4'h7 : 4'h0;
    end
    else if (pending && wait_cnt != 4'h0)
      wait_cnt <= wait_cnt - 4'h1;
    else if (pending)
    begin
      pending <= 1'b0;
      adc_done <= 1'b1;
      adc_data <= adc_phase_select ? phase_level : 8'hFF - antenna_driver_out_a;
    end
  end
endmodule

/* File: verif/am_depth_antenna_tune_cal_tb.sv */
// Purpose: Self-checking bench for the calibration sequencer.
// Assumes: Settle counts are fixed at 1000 cycles.
// Notes:   Depth runs start near the top code to keep the run short.
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module am_depth_antenna_tune_cal_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import amc_pkg::*;
  logic       core_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic       tx_enable_request = 1'b0;
  logic       am_modulate = 1'b0;
  logic       slow = 1'b0;
  logic [4:0] res_point = 5'h00;
  logic [7:0] phase_level = 8'h80;
  logic [7:0] reg_rdata, antenna_driver_out_a, antenna_driver_out_b, adc_data;
  logic [3:0] tuning_switch_a, tuning_switch_b;
  logic       tx_enable, adc_start, adc_relative, adc_phase_select, adc_done, phase_comp_async, busy;
  int         n_mismatch = 0;
  int         tests_run = 0;
  integer     seed = 32'h75a03061;
  logic [7:0] rd, nm, ex, al;
  logic [5:0] fr;
  logic [4:0] rp;
  logic [5:0] ra [7] = '{ADDR_ADC_OUT, ADDR_ANT_CAL, ADDR_DEPTH_DEF, ADDR_DEPTH_DISP,
                         ADDR_AM_LEVEL, ADDR_NONMOD_LVL, 6'h3F};

  always #5 core_clk = ~core_clk;
  amc_cal_seq i_amc_cal_seq (.*);
  amc_far_side i_amc_far_side (.*);

  function automatic logic [7:0] ant_exp(input logic [4:0] p);
    if (p == 5'h00)
      return 8'h10;
    if (p >= 5'h10)
      return 8'h1F;
    return {4'h0, p[3:0]};
  endfunction

  function automatic logic [7:0] dep_exp(input logic [7:0] n, input logic [5:0] f);
    int r;
    r = 255 - ((255 - n) * 64) / (64 + f);
    if (n == 8'hFF)
      return 8'hFF;
    if (r < n + 1)
      r = n + 1;
    return r[7:0];
  endfunction

  task automatic stop_test();
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rdr(input logic [5:0] a);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    rd = reg_rdata;
  endtask

  task automatic cmd(input logic [7:0] c);
    int i;
    wr(ADDR_COMMAND, c);
    @(negedge core_clk);
    `CHK("busy", 1'b1, busy)
    // A second command while one runs must be ignored.
    if (c == CMD_CAL_DEPTH)
      wr(ADDR_COMMAND, CMD_CAL_ANTENNA);
    for (i = 0; i < 30000 && busy !== 1'b0; i++)
      @(negedge core_clk);
    if (busy !== 1'b0)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask

  task automatic settle();
    repeat (3) @(negedge core_clk);
  endtask

  initial
  begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (ra[k])
    begin
      rdr(ra[k]);
      `CHK("reset_value", 8'h00, rd)
    end
    wr(ADDR_DEPTH_DISP, 8'hA5);
    rdr(ADDR_DEPTH_DISP);
    `CHK("depth_disp_ro", 8'h00, rd)
    wr(ADDR_DEPTH_DEF, 8'hFF);
    rdr(ADDR_DEPTH_DEF);
    `CHK("depth_def", 8'hFE, rd)
    @(posedge core_clk);
    tx_enable_request <= 1'b1;
    settle();
    `CHK("tx_request", 1'b1, tx_enable)
    @(posedge core_clk);
    tx_enable_request <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      rp = (k == 0) ? 5'h00 : (k == 1) ? 5'h10 : 5'($unsigned($random(seed)) % 15) + 5'h01;
      @(posedge core_clk);
      res_point <= rp;
      slow <= k[0];
      cmd(CMD_CAL_ANTENNA);
      rdr(ADDR_ANT_CAL);
      `CHK("ant_cal", ant_exp(rp), rd)
    end
    for (int k = 0; k < 3; k++)
    begin
      @(posedge core_clk);
      phase_level <= (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : 8'($random(seed));
      cmd(CMD_CHECK_RES);
      rdr(ADDR_ADC_OUT);
      `CHK("check_res", phase_level, rd)
      `CHK("relative", 1'b1, adc_relative & adc_phase_select)
    end
    for (int k = 0; k < 3; k++)
    begin
      nm = (k == 1) ? 8'hFF : 8'hF0 | 8'($random(seed) & 15);
      fr = (k == 2) ? 6'h00 : 6'($random(seed));
      ex = dep_exp(nm, fr);
      al = 8'($random(seed));
      wr(ADDR_NONMOD_LVL, nm);
      wr(ADDR_DEPTH_DEF, {1'b0, fr, 1'b0});
      cmd(CMD_CAL_DEPTH);
      rdr(ADDR_DEPTH_DISP);
      `CHK("depth_disp", ex, rd)
      rdr(ADDR_ANT_CAL);
      `CHK("ant_kept", ant_exp(rp), rd)
      @(posedge core_clk);
      am_modulate <= 1'b1;
      settle();
      `CHK("drv_mod", ex, antenna_driver_out_a)
      wr(ADDR_AM_LEVEL, al);
      wr(ADDR_DEPTH_DEF, {1'b1, fr, 1'b0});
      settle();
      `CHK("drv_host", al, antenna_driver_out_a)
      @(posedge core_clk);
      am_modulate <= 1'b0;
      settle();
      `CHK("drv_nonmod", nm, antenna_driver_out_a)
      cmd(CMD_MEASURE_RF);
      rdr(ADDR_ADC_OUT);
      `CHK("measure_rf", 8'hFF - nm, rd)
    end
    @(posedge core_clk);
    res_point <= 5'h10;
    wr(ADDR_COMMAND, CMD_CAL_ANTENNA);
    repeat (1500) @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    `CHK("busy_after_reset", 1'b0, busy)
    `CHK("trim_after_reset", 4'h0, tuning_switch_a)
    stop_test();
  end
endmodule
